// ### rtl/otcg_pkg.sv
// constants, register map and field layout of the oscillator trim and
// clock generation block.
// assumes a 100 MHz core clock and word-aligned Avalon-MM byte addresses.
package otcg_pkg;

	// --------------------------------------------------------------
	// register offsets (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] OTCG_REG_TRIM    = 8'h00;
	localparam logic [7:0] OTCG_REG_TCTL    = 8'h04;
	localparam logic [7:0] OTCG_REG_STAT    = 8'h08;
	localparam logic [7:0] OTCG_REG_RCCTL   = 8'h0c;
	localparam logic [7:0] OTCG_REG_CALN    = 8'h10;
	localparam logic [7:0] OTCG_REG_CALSEL  = 8'h14;
	localparam logic [7:0] OTCG_REG_CALLO   = 8'h18;
	localparam logic [7:0] OTCG_REG_CALHI   = 8'h1c;
	localparam logic [7:0] OTCG_REG_PER     = 8'h20;
	localparam logic [7:0] OTCG_REG_SPIDIV  = 8'h24;
	localparam logic [7:0] OTCG_REG_IRQSTS  = 8'h28;
	localparam logic [7:0] OTCG_REG_IRQCLR  = 8'h2c;
	localparam logic [7:0] OTCG_REG_IRQEN   = 8'h30;

	// --------------------------------------------------------------
	// field layout and reset values
	// --------------------------------------------------------------
	localparam int          OTCG_TRIM_W     = 11;
	localparam logic [10:0] OTCG_TRIM_RST   = 11'h400;
	localparam int          OTCG_DLY_LSB    = 0;
	localparam int          OTCG_SETTLE_LSB = 4;
	localparam int          OTCG_XEN_BIT    = 8;
	localparam int          OTCG_TCTL_W     = 9;
	localparam int          OTCG_ST_TRIM    = 0;
	localparam int          OTCG_ST_SETTLED = 1;
	localparam int          OTCG_ST_SYSXTAL = 2;
	localparam int          OTCG_RCTRIM_W   = 5;
	localparam logic [4:0]  OTCG_RCTRIM_RST = 5'h00;
	localparam int          OTCG_CAL_START  = 2;
	localparam int          OTCG_IRQ_W      = 3;
	localparam int          OTCG_IRQ_TRIM   = 0;
	localparam int          OTCG_IRQ_SETTLE = 1;
	localparam int          OTCG_IRQ_CAL    = 2;
	localparam int          OTCG_PER_SPI    = 0;

	// calibration source field, start bit above it gives codes 4..7
	localparam logic [1:0] OTCG_SRC_SLOW_RC   = 2'h0;
	localparam logic [1:0] OTCG_SRC_FAST_RC   = 2'h1;
	localparam logic [1:0] OTCG_SRC_SLOW_XTAL = 2'h2;
	localparam logic [1:0] OTCG_SRC_ENH_RC    = 2'h3;
	localparam int         OTCG_XTAL_IDX      = 4;

	// serial clock divider terminal counts (divisor minus one)
	localparam logic [3:0] OTCG_SPI_LIM2  = 4'h1;
	localparam logic [3:0] OTCG_SPI_LIM4  = 4'h3;
	localparam logic [3:0] OTCG_SPI_LIM8  = 4'h7;
	localparam logic [3:0] OTCG_SPI_LIM14 = 4'hd;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int OTCG_CORE_MHZ     = 100;
	localparam int OTCG_INTERVAL_US  = 250;
	localparam int OTCG_INTERVAL_CYC = OTCG_INTERVAL_US * OTCG_CORE_MHZ;

	typedef enum logic [1:0] {
		OTCG_IDLE,
		OTCG_TRIM,
		OTCG_SETTLE,
		OTCG_DONE
	} otcg_xstate_t;

endpackage

// ### rtl/otcg_thermo_dec.sv
// 3-to-7 thermometer decoder for the coarse crystal capacitors.
// assumes a registered code at its input; output is combinational.
`timescale 1ns/1ns
`default_nettype none
module otcg_thermo_dec (
	input  wire logic [2:0] i_code,
	output logic      [6:0] o_therm
);
	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	genvar k;
	generate
		for (k = 0; k < 7; k++) begin : g_bit
			if (k == 0) begin : g_lsb
				assign o_therm[k] = 1'b1; // codes 0 and 1 alike
			end else begin : g_hi
				assign o_therm[k] = (i_code >= 3'(k + 1));
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### rtl/otcg_interval_timer.sv
// counts a programmed number of fixed-length intervals, then pulses done.
// assumes start and abort come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module otcg_interval_timer #(
	parameter int CYC = 25000
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_start,
	input  wire logic       i_abort,
	input  wire logic [3:0] i_count,
	output logic            o_done
);
	localparam int CW = (CYC > 1) ? $clog2(CYC) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYC - 1);

	logic          busy_r;
	logic [CW-1:0] cyc_r;
	logic [3:0]    left_r;
	logic          done_r;
	wire           tick = busy_r & (cyc_r == LAST);

	assign o_done = done_r;

	// --------------------------------------------------------------
	// interval counter; zero count finishes on the next edge
	// --------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_r <= 1'b0;
			cyc_r  <= '0;
			left_r <= 4'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= (i_start & ~i_abort & (i_count == 4'h0))
			          | (tick & (left_r == 4'h1) & ~i_abort);
			if (i_abort) begin
				busy_r <= 1'b0;
			end else if (i_start) begin
				busy_r <= (i_count != 4'h0);
				cyc_r  <= '0;
				left_r <= i_count;
			end else if (tick) begin
				cyc_r  <= '0;
				left_r <= left_r - 4'h1;
				busy_r <= (left_r != 4'h1);
			end else if (busy_r) begin
				cyc_r <= cyc_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/otcg_top.sv
// oscillator trim sequencer, reference counter and clock enables.
// assumes oscillator clocks arrive as asynchronous pins, sampled here,
// and an Avalon-MM master issuing full 32-bit word accesses.
`timescale 1ns/1ns
`default_nettype none
module otcg_top
	import otcg_pkg::*;
#(
	parameter int PER_N        = 8,
	parameter int INTERVAL_CYC = OTCG_INTERVAL_CYC
) (
	input  wire logic             I_CORE_CLK,
	input  wire logic             I_RST_N,
	input  wire logic [7:0]       I_AVS_ADDRESS,
	input  wire logic             I_AVS_READ,
	input  wire logic             I_AVS_WRITE,
	input  wire logic [31:0]      I_AVS_WRITEDATA,
	output logic      [31:0]      O_AVS_READDATA,
	output logic                  O_AVS_WAITREQUEST,
	input  wire logic [3:0]       I_OSC_CLK,
	input  wire logic             I_FAST_XTAL_CLK,
	output logic                  O_FAST_XTAL_EN,
	output logic      [7:0]       O_TRIM_FINE,
	output logic      [6:0]       O_TRIM_COARSE,
	output logic      [4:0]       O_FAST_RC_TRIM,
	output logic                  O_SYSCLK_XTAL,
	output logic      [PER_N-1:0] O_PER_CLK_EN,
	output logic                  O_SPI_CLK_EN,
	output logic                  O_IRQ
);
	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	logic [10:0]           trim_r;
	logic [10:0]           app_r;
	logic [8:0]            tctl_r;
	logic [4:0]            rctl_r;
	logic [31:0]           caln_r;
	logic [1:0]            csrc_r;
	logic [PER_N-1:0]      per_r;
	logic [1:0]            spidiv_r;
	logic [2:0]            ists_r;
	logic [2:0]            ien_r;
	logic                  wait_r;
	logic [31:0]           rdata_r;
	logic                  xen_d_r;
	otcg_xstate_t          xst_r;
	otcg_xstate_t          xst_nxt;
	logic [6:0]            coarse_r;
	logic                  sys_r;
	logic                  irq_r;
	logic                  cbusy_r;
	logic [31:0]           m_r;
	logic [31:0]           ncnt_r;
	logic [31:0]           res_r;
	logic                  cdone_r;
	logic [3:0]            dcnt_r;
	logic                  spi_r;
	logic [4:0]            s1_r;
	logic [4:0]            s2_r;
	logic [4:0]            s3_r;
	logic [6:0]            therm;
	logic                  trim_done;
	logic                  settle_done;

	// --------------------------------------------------------------
	// bus decode
	// --------------------------------------------------------------
	// one wait state: writes are taken on the edge with waitrequest low, read data is captured on the edge before
	wire wr      = I_AVS_WRITE & ~wait_r;
	wire rd_take = I_AVS_READ & wait_r;
	wire s_trim  = (I_AVS_ADDRESS == OTCG_REG_TRIM);
	wire s_tctl  = (I_AVS_ADDRESS == OTCG_REG_TCTL);
	wire s_stat  = (I_AVS_ADDRESS == OTCG_REG_STAT);
	wire s_rctl  = (I_AVS_ADDRESS == OTCG_REG_RCCTL);
	wire s_caln  = (I_AVS_ADDRESS == OTCG_REG_CALN);
	wire s_csel  = (I_AVS_ADDRESS == OTCG_REG_CALSEL);
	wire s_clo   = (I_AVS_ADDRESS == OTCG_REG_CALLO);
	wire s_chi   = (I_AVS_ADDRESS == OTCG_REG_CALHI);
	wire s_per   = (I_AVS_ADDRESS == OTCG_REG_PER);
	wire s_sdiv  = (I_AVS_ADDRESS == OTCG_REG_SPIDIV);
	wire s_ists  = (I_AVS_ADDRESS == OTCG_REG_IRQSTS);
	wire s_iclr  = (I_AVS_ADDRESS == OTCG_REG_IRQCLR);
	wire s_ien   = (I_AVS_ADDRESS == OTCG_REG_IRQEN);

	// status word seen by software
	wire trim_flag = (xst_r == OTCG_SETTLE) | (xst_r == OTCG_DONE);
	wire settled   = (xst_r == OTCG_DONE);
	wire [2:0] stat_w = {sys_r, settled, trim_flag};

	// read mux; unmapped and write-only offsets read as zero
	wire [31:0] rd_mux =
		s_trim ? 32'(trim_r) :
		s_tctl ? 32'(tctl_r) :
		s_stat ? 32'(stat_w) :
		s_rctl ? 32'(rctl_r) :
		s_caln ? caln_r :
		s_csel ? 32'({cbusy_r, csrc_r}) :
		s_clo  ? 32'(res_r[15:0]) :
		s_chi  ? 32'(res_r[31:16]) :
		s_per  ? 32'(per_r) :
		s_sdiv ? 32'(spidiv_r) :
		s_ists ? 32'(ists_r) :
		s_ien  ? 32'(ien_r) : 32'h0000_0000;

	// bus handshake and read data capture
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			wait_r <= ~((I_AVS_READ | I_AVS_WRITE) & wait_r);
			if (rd_take) begin
				rdata_r <= rd_mux;
			end
		end
	end

	assign O_AVS_WAITREQUEST = wait_r;
	assign O_AVS_READDATA    = rdata_r;

	// --------------------------------------------------------------
	// control registers
	// --------------------------------------------------------------
	// full 11-bit trim code, reset value mid range
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			trim_r   <= OTCG_TRIM_RST;
			tctl_r   <= '0;
			rctl_r   <= OTCG_RCTRIM_RST; // rc starts slowest
			caln_r   <= 32'h0000_0000;
			csrc_r   <= OTCG_SRC_SLOW_RC;
			per_r    <= '0;
			spidiv_r <= 2'h0;
			ien_r    <= 3'h0;
		end else if (wr) begin
			if (s_trim) trim_r <= I_AVS_WRITEDATA[10:0];
			if (s_tctl) tctl_r <= I_AVS_WRITEDATA[8:0];
			if (s_rctl) rctl_r <= I_AVS_WRITEDATA[4:0];
			if (s_caln) caln_r <= I_AVS_WRITEDATA;
			if (s_csel & ~cbusy_r) csrc_r <= I_AVS_WRITEDATA[1:0];
			if (s_per) per_r <= I_AVS_WRITEDATA[PER_N-1:0];
			if (s_sdiv) spidiv_r <= I_AVS_WRITEDATA[1:0];
			if (s_ien) ien_r <= I_AVS_WRITEDATA[2:0];
		end
	end

	// --------------------------------------------------------------
	// oscillator pin synchronisers
	// --------------------------------------------------------------
	wire [4:0] osc_raw = {I_FAST_XTAL_CLK, I_OSC_CLK};
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_sync
			// first stage feeds only the second
			always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
				if (!I_RST_N) begin
					s1_r[g] <= 1'b0;
					s2_r[g] <= 1'b0;
					s3_r[g] <= 1'b0;
				end else begin
					s1_r[g] <= osc_raw[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
				end
			end
		end
	endgenerate
	wire [4:0] osc_edge = s2_r & ~s3_r;

	// --------------------------------------------------------------
	// crystal trim sequencer
	// --------------------------------------------------------------
	wire       xen     = tctl_r[OTCG_XEN_BIT];
	wire       xen_up  = xen & ~xen_d_r;
	wire [3:0] dly_f   = tctl_r[OTCG_DLY_LSB +: 4];
	wire [3:0] stl_f   = tctl_r[OTCG_SETTLE_LSB +: 4];

	// trim delay in 250 us units, zero delay is immediate
	otcg_interval_timer #(
		.CYC (INTERVAL_CYC)
	) u_trim_tmr (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_start (xen_up),
		.i_abort (~xen),
		.i_count (dly_f),
		.o_done  (trim_done)
	);

	// settle count starts when trim ready asserts
	otcg_interval_timer #(
		.CYC (INTERVAL_CYC)
	) u_settle_tmr (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_start (trim_done),
		.i_abort (~xen),
		.i_count (stl_f),
		.o_done  (settle_done)
	);

	// sequencer next state; disabling the crystal drops all flags
	always_comb begin
		xst_nxt = xst_r;
		case (xst_r)
			OTCG_IDLE:   if (xen_up) xst_nxt = OTCG_TRIM;
			OTCG_TRIM:   if (trim_done) xst_nxt = OTCG_SETTLE;
			OTCG_SETTLE: if (settle_done) xst_nxt = OTCG_DONE;
			OTCG_DONE:   xst_nxt = OTCG_DONE;
			default:     xst_nxt = OTCG_IDLE;
		endcase
		if (!xen) xst_nxt = OTCG_IDLE;
	end

	// fine bits pass undecoded; applied code tracks after ready
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			xst_r   <= OTCG_IDLE;
			xen_d_r <= 1'b0;
			app_r   <= OTCG_TRIM_RST;
			coarse_r <= 7'h0f; // thermometer of the reset code
			sys_r   <= 1'b0;
		end else begin
			xst_r   <= xst_nxt;
			xen_d_r <= xen;
			if (trim_done | trim_flag) app_r <= trim_r;
			coarse_r <= therm; // one coarse capacitor per bit
			sys_r   <= settled; // rc clocks until settled
		end
	end

	// coarse bits through the thermometer decoder
	otcg_thermo_dec u_dec (
		.i_code  (app_r[10:8]),
		.o_therm (therm)
	);

	assign O_FAST_XTAL_EN = xen;
	assign O_TRIM_FINE    = app_r[7:0];
	assign O_TRIM_COARSE  = coarse_r;
	assign O_SYSCLK_XTAL  = sys_r;
	assign O_FAST_RC_TRIM = rctl_r;

	// --------------------------------------------------------------
	// reference counter
	// --------------------------------------------------------------
	// codes 4..7: start bit above the source field
	wire        cstart  = wr & s_csel & I_AVS_WRITEDATA[OTCG_CAL_START]
	                      & ~cbusy_r;
	// slow crystal is only measured here, never trimmed
	wire        m_edge  = osc_edge[csrc_r];
	wire        x_edge  = osc_edge[OTCG_XTAL_IDX];
	wire [31:0] m_fin   = m_r + 32'(x_edge);
	wire        c_last  = cbusy_r & m_edge & (ncnt_r + 32'h1 == caln_r);

	// crystal edges counted over n measured edges
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cbusy_r <= 1'b0;
			m_r     <= 32'h0000_0000;
			ncnt_r  <= 32'h0000_0000;
			res_r   <= 32'h0000_0000;
			cdone_r <= 1'b0;
		end else begin
			cdone_r <= cstart & (caln_r == 32'h0) | c_last;
			if (cstart) begin
				cbusy_r <= (caln_r != 32'h0);
				m_r     <= 32'h0000_0000;
				ncnt_r  <= 32'h0000_0000;
				if (caln_r == 32'h0) res_r <= 32'h0000_0000;
			end else if (cbusy_r) begin
				m_r <= m_fin;
				if (m_edge) ncnt_r <= ncnt_r + 32'h1;
				// start bit drops with the final count
				if (c_last) begin
					cbusy_r <= 1'b0;
					res_r   <= m_fin;
				end
			end
		end
	end

	// --------------------------------------------------------------
	// peripheral clock gates and serial clock divider
	// --------------------------------------------------------------
	wire       spi_on = per_r[OTCG_PER_SPI];
	wire [3:0] d_lim  = (spidiv_r == 2'h0) ? OTCG_SPI_LIM2 :
	                    (spidiv_r == 2'h1) ? OTCG_SPI_LIM4 :
	                    (spidiv_r == 2'h2) ? OTCG_SPI_LIM8 : OTCG_SPI_LIM14;

	// enable pulse every 2, 4, 8 or 14 cycles while gated on
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			dcnt_r <= 4'h0;
			spi_r  <= 1'b0;
		end else if (!spi_on) begin
			dcnt_r <= 4'h0;
			spi_r  <= 1'b0;
		end else begin
			spi_r  <= (dcnt_r >= d_lim);
			dcnt_r <= (dcnt_r >= d_lim) ? 4'h0 : dcnt_r + 4'h1;
		end
	end

	// each module clock gate driven by its enable bit
	assign O_PER_CLK_EN = per_r;
	assign O_SPI_CLK_EN = spi_r;

	// --------------------------------------------------------------
	// interrupts
	// --------------------------------------------------------------
	wire [2:0] ievt = {cdone_r, settle_done & xen, trim_done & xen};
	wire [2:0] iclr = (wr & s_iclr) ? I_AVS_WRITEDATA[2:0] : 3'h0;

	// set wins over a clear in the same cycle
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ists_r <= 3'h0;
			irq_r  <= 1'b0;
		end else begin
			ists_r <= (ists_r & ~iclr) | ievt;
			irq_r  <= |(ists_r & ien_r);
		end
	end
	assign O_IRQ = irq_r;

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	wire [7:0] trim_fine_w = trim_r[7:0];
	wire [2:0] app_top_w   = app_r[10:8];

	a_trim_apply: assert property (
		$rose(trim_flag) |-> app_r == $past(trim_r))
		else $error("trim code not applied at ready");
	a_fine_bits: assert property (
		$rose(trim_flag) |-> O_TRIM_FINE == $past(trim_fine_w))
		else $error("fine bits differ from trim code");
	a_coarse_therm: assert property (
		O_TRIM_COARSE[0] && O_TRIM_COARSE[6:1] ==
		(6'h3f >> (3'h7 - $past(app_top_w))))
		else $error("coarse thermometer wrong");
	a_zero_delay: assert property (
		xen_up && dly_f == 4'h0 |-> ##[1:2] trim_flag)
		else $error("zero delay trim not immediate");
	a_settle_order: assert property (
		$rose(settled) |-> $past(trim_flag))
		else $error("settled before trim ready");
	a_cal_result: assert property (
		c_last |=> !cbusy_r && res_r == $past(m_fin))
		else $error("calibration result wrong");
	a_cal_busy: assert property (
		cstart && caln_r > 32'h1 |=> cbusy_r [*2])
		else $error("start bit not held while busy");
	a_sys_rc: assert property (
		!settled |=> !O_SYSCLK_XTAL)
		else $error("crystal chosen before settled");
	a_spi_gap: assert property (
		O_SPI_CLK_EN |=> !O_SPI_CLK_EN)
		else $error("serial clock enable too dense");
	a_bus_wait: assert property (
		!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("waitrequest low two cycles");

	c_settled: cover property ($rose(settled));
	c_cal_done: cover property (c_last);
	c_spi14: cover property (O_SPI_CLK_EN && spidiv_r == 2'h3);
	c_irq: cover property ($rose(O_IRQ));
endmodule
`default_nettype wire

// ### rtl/otcg_fix.sv
`timescale 1ns/1ns

// ### tb/otcg_top_test.sv
// self-checking bench for the oscillator trim and clock generation block.
// assumes the package and design files are compiled first; the bench
// drives the Avalon-MM slave and makes the oscillator clocks itself.
`timescale 1ns/1ns
`default_nettype none
module otcg_top_test;
	import otcg_pkg::*;

	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic        clk   = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr  = 8'h00;
	logic        rd    = 1'b0;
	logic        wr    = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  osc   = 4'h0;
	logic        xclk  = 1'b0;
	logic [2:0]  ocnt [4] = '{default: 3'h0};
	logic [1:0]  xcnt  = 2'h0;
	logic [31:0] rdata;
	logic        wreq, xen, sysx, irq, spi;
	logic [7:0]  fine, per;
	logic [6:0]  coarse;
	logic [4:0]  rct;
	int          fails = 0;
	int          checks_done = 0;

	// short interval so a 250 us step is ten core cycles
	otcg_top #(.PER_N(8), .INTERVAL_CYC(10)) otcg_top_i (
		.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(addr),
		.I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
		.I_OSC_CLK(osc), .I_FAST_XTAL_CLK(xclk), .O_FAST_XTAL_EN(xen),
		.O_TRIM_FINE(fine), .O_TRIM_COARSE(coarse), .O_FAST_RC_TRIM(rct),
		.O_SYSCLK_XTAL(sysx), .O_PER_CLK_EN(per), .O_SPI_CLK_EN(spi),
		.O_IRQ(irq));

	// 100 MHz core clock
	always #5 clk = ~clk;

	// crystal at period 6, oscillator k at period 2*(k+3) core cycles
	always @(posedge clk) begin
		xcnt <= (xcnt == 2'h2) ? 2'h0 : xcnt + 2'h1;
		if (xcnt == 2'h2) xclk <= ~xclk;
		for (int k = 0; k < 4; k++) begin
			ocnt[k] <= (ocnt[k] == 3'(k + 2)) ? 3'h0 : ocnt[k] + 3'h1;
			if (ocnt[k] == 3'(k + 2)) osc[k] <= ~osc[k];
		end
	end

	// ----------------------------------------------------------------
	// checking, verdict and bus tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict;
		if (fails == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// one access; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
		if (n >= 20) begin fails++; print_verdict; end
	endtask

	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input string what, input logic [7:0] a,
			input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(what, q, exp);
	endtask

	// edges until irq (0), settled (1) or serial pulse (2) is seen
	task automatic wait_sig(input int s, input int lim, output int n);
		n = 0;
		while (((s == 0) ? irq : (s == 1) ? sysx : spi) !== 1'b1
				&& n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin fails++; print_verdict; end
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		print_verdict;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [6:0]  tbl [8];
		logic [31:0] q, lo, m;
		logic [7:0]  f;
		int          n, ex;
		tbl = '{7'h01, 7'h01, 7'h03, 7'h07, 7'h0f, 7'h1f, 7'h3f, 7'h7f};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc("trim_reset", OTCG_REG_TRIM, 32'h400);
		check("coarse_reset", coarse, 32'h0f);
		check("rc_trim_pin", rct, 32'h0);
		rdc("rc_trim_reset", OTCG_REG_RCCTL, 32'h0);
		wr32(8'h3c, 32'hffff_ffff);
		rdc("unmapped", 8'h3c, 32'h0);
		wr32(OTCG_REG_RCCTL, 32'h1f);
		check("rc_trim_set", rct, 32'h1f);
		// delay 2 and settle 1 intervals
		wr32(OTCG_REG_IRQEN, 32'h1);
		wr32(OTCG_REG_TRIM, 32'h0ab);
		wr32(OTCG_REG_TCTL, 32'h112);
		check("xtal_en", xen, 32'h1);
		wait_sig(0, 60, n);
		check("trim_delay", (n >= 16) && (n <= 26), 32'h1);
		check("fine_applied", fine, 32'hab);
		check("coarse_applied", coarse, 32'h01);
		check("still_rc", sysx, 32'h0);
		wait_sig(1, 60, n);
		check("settle_time", (n >= 7) && (n <= 14), 32'h1);
		rdc("status", OTCG_REG_STAT, 32'h7);
		rdc("irq_status", OTCG_REG_IRQSTS, 32'h3);
		wr32(OTCG_REG_IRQEN, 32'h0);
		repeat (2) @(posedge clk);
		check("irq_masked", irq, 32'h0);
		wr32(OTCG_REG_IRQCLR, 32'h3);
		rdc("irq_cleared", OTCG_REG_IRQSTS, 32'h0);
		wr32(OTCG_REG_IRQEN, 32'h7);
		wr32(OTCG_REG_TCTL, 32'h0);
		repeat (2) @(posedge clk);
		check("flags_drop", sysx, 32'h0);
		wr32(OTCG_REG_TRIM, 32'h0cc);
		wr32(OTCG_REG_TCTL, 32'h100);
		wait_sig(0, 6, n);
		check("fine_now", fine, 32'hcc);
		// every coarse code, both trim end points
		for (int c = 0; c < 8; c++) begin
			f = (c == 7) ? 8'hff : (c == 0) ? 8'h00 : 8'h5a;
			wr32(OTCG_REG_TRIM, {21'h0, 3'(c), f}); // one coarse step
			repeat (8) @(posedge clk); // settle wait, scaled
			check("fine", fine, {24'h0, f});
			check("thermometer", coarse, {25'h0, tbl[c]});
		end
		wr32(OTCG_REG_IRQCLR, 32'h7);
		// every source with N of four
		for (int k = 0; k < 4; k++) begin
			wr32(OTCG_REG_CALN, 32'h4);
			wr32(OTCG_REG_CALSEL, 32'(4 + k));
			rdc("cal_busy", OTCG_REG_CALSEL, 32'(4 + k));
			n = 0;
			do begin
				bus(1'b0, OTCG_REG_CALSEL, 32'h0, q);
				n++;
			end while (q[2] !== 1'b0 && n < 30);
			check("cal_done", {31'h0, q[2]}, 32'h0);
			bus(1'b0, OTCG_REG_CALLO, 32'h0, lo);
			bus(1'b0, OTCG_REG_CALHI, 32'h0, q);
			m = {q[15:0], lo[15:0]};
			ex = 8 * (k + 3) / 6;
			check("cal_count", (m + 2 >= ex) && (m <= ex + 2), 32'h1);
		end
		rdc("cal_irq", OTCG_REG_IRQSTS, 32'h4);
		check("irq_level", irq, 32'h1);
		wr32(OTCG_REG_CALN, 32'h0);
		wr32(OTCG_REG_CALSEL, 32'h4);
		rdc("cal_zero_done", OTCG_REG_CALSEL, 32'h0);
		rdc("cal_zero_m", OTCG_REG_CALLO, 32'h0);
		wr32(OTCG_REG_PER, 32'ha5); // gates only, serial divider setting kept
		check("per_enables", per, 32'ha5);
		for (int s = 0; s < 4; s++) begin
			wr32(OTCG_REG_SPIDIV, 32'(s));
			wait_sig(2, 40, n);
			@(posedge clk);
			wait_sig(2, 40, n);
			ex = (s == 3) ? 14 : 2 << s;
			check("spi_div", n + 1, ex);
		end
		wr32(OTCG_REG_PER, 32'h0);
		n = 0;
		repeat (20) begin
			@(posedge clk);
			if (spi !== 1'b0) n++;
		end
		check("spi_gated", n, 32'h0);
		print_verdict;
	end

endmodule
`default_nettype wire
